// ---- src/arc_defines.vh ----
`ifndef ARC_DEFINES_VH
`define ARC_DEFINES_VH

// Sizes
`define ARC_CHANS      18
`define ARC_ALMS       5
`define ARC_SLOTS      90
`define ARC_RELAYS     12
`define ARC_RATE_MAX_S 10'd600

// Seconds tick
`define ARC_TICK_S     1
`define ARC_CLK_MHZ    250
`define ARC_TICK_CYC   (`ARC_TICK_S * `ARC_CLK_MHZ * 1000000)

// Register byte offsets
`define ARC_CTRL       12'h000
`define ARC_CH_EN      12'h004
`define ARC_CH_KIND    12'h008
`define ARC_STATUS     12'h00C
`define ARC_RLY_EN     12'h010
`define ARC_RLY_FS     12'h014
`define ARC_RLY_OOR    12'h018
`define ARC_RLY_ACKC   12'h01C
`define ARC_RLY_TYPE   12'h020
`define ARC_CMD        12'h024
`define ARC_MAN_SET    12'h028
`define ARC_MAN_RST    12'h02C
`define ARC_RLY_STATE  12'h030
`define ARC_CH_ALARM   12'h034
`define ARC_SLOT_BASE  2'b01

// Control, command and status bits
`define ARC_CTRL_ALM   0
`define ARC_CTRL_OUT   1
`define ARC_CMD_ACK    0
`define ARC_CMD_RST    1
`define ARC_CMD_ERRCLR 2
`define ARC_ST_SUM     0
`define ARC_ST_MUTE    1
`define ARC_ST_ERR     2

// Slot configuration word
`define ARC_CFG_W      61
`define ARC_C_SP       15:0
`define ARC_C_DB       31:16
`define ARC_C_DLY      41:32
`define ARC_C_WIN      51:42
`define ARC_C_TYP      54:52
`define ARC_C_EN       55
`define ARC_C_REC      56
`define ARC_C_REL      60:57

// Slot state word
`define ARC_ST_W       38
`define ARC_S_ACT      0
`define ARC_S_DCNT     10:1
`define ARC_S_REF      26:11
`define ARC_S_WCNT     36:27
`define ARC_S_HIT      37

// Alarm types
`define ARC_T_NONE     3'd0
`define ARC_T_HIGH     3'd1
`define ARC_T_LOW      3'd2
`define ARC_T_RATE     3'd3
`define ARC_T_ABN      3'd4
`define ARC_T_TRUE     3'd5
`define ARC_T_FALSE    3'd6

// Relay types
`define ARC_R_NORMAL   2'd0
`define ARC_R_LATCH    2'd1
`define ARC_R_REFLASH  2'd2

`endif

// ---- src/arc_mem.v ----
`timescale 1ns/1ps
module arc_mem #(
  parameter W = 8,
  parameter D = 90
) (
  // Clock
  input  wire         pclk,
  // Write port
  input  wire         we,
  input  wire [6:0]   waddr,
  input  wire [W-1:0] wdata,
  // Read port
  input  wire [6:0]   raddr,
  output reg  [W-1:0] rdata
);
  reg [W-1:0] mem [0:D-1];

  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // arc_mem

// ---- src/arc_top.v ----
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "arc_defines.vh"

// Behaviour
// - Five separately configured alarm slots per channel, eighteen channels.
// - Analog: none/high/low/rate/abnormal; contact: none/true/false/abnormal.
// - Slot active only with slot, channel and global alarm enables.
// - High alarm true while value exceeds setpoint.
// - Low alarm true while value below setpoint.
// - Active high alarm clears at setpoint minus dead band, low at setpoint plus dead band; then setpoint again.
// - Dead band never larger than setpoint; limited to it.
// - Alarm reported only after condition held for delay seconds.
// - Rate alarm when change exceeds setpoint within window up to 600 s.
// - Positive rate setpoint watches rises, negative watches falls.
// - Activation of slot with record option pulses record start.
// - Each slot selects one enabled relay or none.
// - Up to twelve relay outputs.
// - Alarm reset releases latched relays out of alarm and reset-release relays.
// - Normal relay follows alarm, optionally released by acknowledge.
// - Latching relay holds after alarm until acknowledge or reset.
// - Reflash relay briefly opens on each additional alarm.
// - Failsafe relay drive is inverted.
// - Per-relay enable; absent relays forced off.
// - Manual set and reset override at once, only with output enable.
// - Open-on-reset relay drops on alarm reset despite active alarm.
// - Output enable off means no relay operates.
// - Summary status high while any relay active.
// - Acknowledge mutes audible indication, status unchanged.
module arc_top #(
  parameter TICK_CYCLES = `ARC_TICK_CYC,
  parameter [11:0] RELAYS_PRESENT = 12'hfff
) (
  // APB
  input  wire          pclk,
  input  wire          presetn,
  input  wire          psel,
  input  wire          penable,
  input  wire          pwrite,
  input  wire [11:0]   paddr,
  input  wire [31:0]   pwdata,
  output wire          pready,
  output reg  [31:0]   prdata,
  output wire          pslverr,
  // Channel measurements
  input  wire [287:0]  chan_value,
  input  wire [17:0]   chan_abnormal,
  // Outputs
  output reg  [11:0]   relay_drive,
  output reg           relay_summary,
  output reg           alarm_audible,
  output reg           rec_start
);
  // Registers
  reg [1:0]   ctrl;
  reg [17:0]  ch_en;
  reg [17:0]  ch_kind;
  reg [11:0]  rly_en;
  reg [11:0]  rly_fs;
  reg [11:0]  rly_oor;
  reg [11:0]  rly_ackc;
  reg [23:0]  rly_type;
  reg [31:0]  cfg_lo;
  reg         cfg_err;
  reg         muted;
  // Command pulses
  reg         cmd_ack;
  reg         cmd_rst;
  reg [11:0]  man_set;
  reg [11:0]  man_rst;
  // Scanner
  reg         init;
  reg         ph;
  reg [6:0]   idx;
  reg [4:0]   ch;
  reg [2:0]   alm;
  reg [27:0]  tick_cnt;
  reg         tick;
  reg         tick_pend;
  reg         sweep_tick;
  reg [11:0]  acc_req;
  reg [11:0]  acc_new;
  reg [17:0]  acc_chan;
  reg [11:0]  alarm_req;
  reg [11:0]  alarm_new;
  reg [17:0]  chan_alarm;
  // Relay state
  reg [11:0]  energ;
  reg [11:0]  ack_hold;
  reg [11:0]  rst_hold;
  reg [11:0]  flash;
  reg [11:0]  man_act;
  reg [11:0]  man_val;
  reg [11:0]  alarm_prev;

  wire                  setup = psel & ~penable;
  wire                  acc   = psel & penable & pready;
  wire                  slot_rg = (paddr[11:10] == `ARC_SLOT_BASE);
  wire [6:0]            w_slot = paddr[9:3];
  wire                  slot_ok = slot_rg & (w_slot < `ARC_SLOTS);
  wire                  reg_ok = (paddr <= `ARC_CH_ALARM) & (paddr[1:0] == 2'b00);
  wire                  wr = acc & pwrite;
  wire [`ARC_CFG_W-1:0] cfg_rd;
  wire [`ARC_ST_W-1:0]  st_rd;
  wire [`ARC_CFG_W-1:0] cfg_new = {pwdata[28:0], cfg_lo};
  wire [6:0]            w_ch = w_slot / 7'd5;
  wire                  kind_c = ch_kind[w_ch[4:0]];
  wire [2:0]            w_typ = pwdata[22:20];
  wire                  commit = wr & slot_ok & paddr[2];
  // Illegal type for channel kind
  wire                  typ_bad = kind_c ?
                          (w_typ != `ARC_T_NONE && w_typ != `ARC_T_ABN &&
                           w_typ != `ARC_T_TRUE && w_typ != `ARC_T_FALSE) :
                          (w_typ > `ARC_T_ABN);
  wire                  cfg_we = init | (commit & ~typ_bad);
  reg [`ARC_ST_W-1:0]   next_st;
  reg                   slot_act;
  reg                   slot_rise;

  assign pready  = ~init;
  assign pslverr = acc & ~(reg_ok | slot_ok);

  arc_mem #(.W(`ARC_CFG_W), .D(`ARC_SLOTS)) u_cfg (
    .pclk  (pclk),
    .we    (cfg_we),
    .waddr (init ? idx : w_slot),
    .wdata (init ? {`ARC_CFG_W{1'b0}} : cfg_new),
    .raddr (idx),
    .rdata (cfg_rd)
  );

  arc_mem #(.W(`ARC_ST_W), .D(`ARC_SLOTS)) u_st (
    .pclk  (pclk),
    .we    (ph | init),
    .waddr (idx),
    .wdata (init ? {`ARC_ST_W{1'b0}} : next_st),
    .raddr (idx),
    .rdata (st_rd)
  );

  // APB writes and registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= 2'b00;
      ch_en    <= 18'h0_0000;
      ch_kind  <= 18'h0_0000;
      rly_en   <= 12'h000;
      rly_fs   <= 12'h000;
      rly_oor  <= 12'h000;
      rly_ackc <= 12'h000;
      rly_type <= 24'h00_0000;
      cfg_lo   <= 32'h0000_0000;
      cfg_err  <= 1'b0;
      cmd_ack  <= 1'b0;
      cmd_rst  <= 1'b0;
      man_set  <= 12'h000;
      man_rst  <= 12'h000;
    end else begin
      cmd_ack <= 1'b0;
      cmd_rst <= 1'b0;
      man_set <= 12'h000;
      man_rst <= 12'h000;
      if (wr && slot_ok && !paddr[2]) begin
        cfg_lo <= pwdata;
      end
      if (commit && typ_bad) begin
        cfg_err <= 1'b1;
      end else if (wr && paddr == `ARC_CMD && pwdata[`ARC_CMD_ERRCLR]) begin
        cfg_err <= 1'b0;
      end
      if (wr) begin
        case (paddr)
          `ARC_CTRL:     ctrl     <= pwdata[1:0];
          `ARC_CH_EN:    ch_en    <= pwdata[17:0];
          `ARC_CH_KIND:  ch_kind  <= pwdata[17:0];
          `ARC_RLY_EN:   rly_en   <= pwdata[11:0] & RELAYS_PRESENT;
          `ARC_RLY_FS:   rly_fs   <= pwdata[11:0];
          `ARC_RLY_OOR:  rly_oor  <= pwdata[11:0];
          `ARC_RLY_ACKC: rly_ackc <= pwdata[11:0];
          `ARC_RLY_TYPE: rly_type <= pwdata[23:0];
          `ARC_CMD: begin
            cmd_ack <= pwdata[`ARC_CMD_ACK];
            cmd_rst <= pwdata[`ARC_CMD_RST];
          end
          `ARC_MAN_SET:  man_set  <= pwdata[11:0] & {12{ctrl[`ARC_CTRL_OUT]}};
          `ARC_MAN_RST:  man_rst  <= pwdata[11:0] & {12{ctrl[`ARC_CTRL_OUT]}};
          default: ;
        endcase
      end
    end
  end

  // Read data captured in setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `ARC_CTRL:      prdata <= {30'h0, ctrl};
        `ARC_CH_EN:     prdata <= {14'h0, ch_en};
        `ARC_CH_KIND:   prdata <= {14'h0, ch_kind};
        `ARC_STATUS:    prdata <= {29'h0, cfg_err, muted, relay_summary};
        `ARC_RLY_EN:    prdata <= {20'h0, rly_en};
        `ARC_RLY_FS:    prdata <= {20'h0, rly_fs};
        `ARC_RLY_OOR:   prdata <= {20'h0, rly_oor};
        `ARC_RLY_ACKC:  prdata <= {20'h0, rly_ackc};
        `ARC_RLY_TYPE:  prdata <= {8'h0, rly_type};
        `ARC_RLY_STATE: prdata <= {20'h0, relay_drive};
        `ARC_CH_ALARM:  prdata <= {14'h0, chan_alarm};
        default:        prdata <= 32'h0000_0000;
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 28'h000_0000;
      tick     <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_CYCLES - 1);
      if (tick_cnt == TICK_CYCLES - 1) begin
        tick_cnt <= 28'h000_0000;
      end else begin
        tick_cnt <= tick_cnt + 28'h000_0001;
      end
    end
  end

  // Slot evaluation
  reg signed [16:0] v17;
  reg signed [16:0] sp17;
  reg signed [16:0] db17;
  reg signed [16:0] dbe;
  reg signed [16:0] diff;
  reg [9:0]         win;
  reg               cond;
  reg               ok_en;
  reg               expire;
  always @* begin
    v17     = {chan_value[{ch, 4'h0} + 15], chan_value[{ch, 4'h0} +: 16]};
    sp17    = {cfg_rd[15], cfg_rd[`ARC_C_SP]};
    db17    = {1'b0, cfg_rd[`ARC_C_DB]};
    diff    = v17 - {st_rd[26], st_rd[`ARC_S_REF]};
    next_st = st_rd;
    ok_en   = cfg_rd[`ARC_C_EN] & ch_en[ch] & ctrl[`ARC_CTRL_ALM];
    if (sp17 <= 17'sd0) begin
      dbe = 17'sd0;
    end else if (db17 > sp17) begin
      dbe = sp17;
    end else begin
      dbe = db17;
    end
    if (cfg_rd[`ARC_C_WIN] > `ARC_RATE_MAX_S) begin
      win = `ARC_RATE_MAX_S;
    end else if (cfg_rd[`ARC_C_WIN] == 10'd0) begin
      win = 10'd1;
    end else begin
      win = cfg_rd[`ARC_C_WIN];
    end
    expire = sweep_tick & ((st_rd[`ARC_S_WCNT] + 10'd1) >= win);
    if (!ok_en) begin
      next_st[`ARC_S_WCNT] = 10'd0;
      next_st[`ARC_S_REF]  = v17[15:0];
      next_st[`ARC_S_HIT]  = 1'b0;
    end else if (expire) begin
      next_st[`ARC_S_WCNT] = 10'd0;
      next_st[`ARC_S_REF]  = v17[15:0];
      next_st[`ARC_S_HIT]  = sp17[16] ? (diff < sp17) : ((sp17 != 0) && (diff > sp17));
    end else if (sweep_tick) begin
      next_st[`ARC_S_WCNT] = st_rd[`ARC_S_WCNT] + 10'd1;
    end
    case (cfg_rd[`ARC_C_TYP])
      `ARC_T_HIGH:  cond = st_rd[`ARC_S_ACT] ? (v17 > sp17 - dbe) : (v17 > sp17);
      `ARC_T_LOW:   cond = st_rd[`ARC_S_ACT] ? (v17 < sp17 + dbe) : (v17 < sp17);
      `ARC_T_RATE:  cond = st_rd[`ARC_S_HIT];
      `ARC_T_ABN:   cond = chan_abnormal[ch];
      `ARC_T_TRUE:  cond = (v17 != 17'sd0);
      `ARC_T_FALSE: cond = (v17 == 17'sd0);
      default:      cond = 1'b0;
    endcase
    if (!ok_en || !cond) begin
      next_st[`ARC_S_ACT]  = 1'b0;
      next_st[`ARC_S_DCNT] = 10'd0;
    end else if (!st_rd[`ARC_S_ACT]) begin
      if (st_rd[`ARC_S_DCNT] >= cfg_rd[`ARC_C_DLY]) begin
        next_st[`ARC_S_ACT] = 1'b1;
      end else if (sweep_tick) begin
        next_st[`ARC_S_DCNT] = st_rd[`ARC_S_DCNT] + 10'd1;
      end
    end
    slot_act  = next_st[`ARC_S_ACT];
    slot_rise = next_st[`ARC_S_ACT] & ~st_rd[`ARC_S_ACT];
  end

  wire [3:0]  rel = cfg_rd[`ARC_C_REL];
  wire [11:0] rel_bit = (rel != 4'd0 && rel <= 4'd12) ? (12'h001 << (rel - 4'd1)) : 12'h000;
  wire        last = (idx == `ARC_SLOTS - 1);
  wire [11:0] req_now = acc_req | (slot_act ? rel_bit : 12'h000);
  wire [11:0] new_now = acc_new | (slot_rise ? rel_bit : 12'h000);
  wire [17:0] chan_now = acc_chan | ({17'h0_0000, slot_act} << ch);

  // Scanner, two cycles per slot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init       <= 1'b1;
      ph         <= 1'b0;
      idx        <= 7'd0;
      ch         <= 5'd0;
      alm        <= 3'd0;
      tick_pend  <= 1'b0;
      sweep_tick <= 1'b0;
      acc_req    <= 12'h000;
      acc_new    <= 12'h000;
      acc_chan   <= 18'h0_0000;
      alarm_req  <= 12'h000;
      alarm_new  <= 12'h000;
      chan_alarm <= 18'h0_0000;
      rec_start  <= 1'b0;
    end else begin
      rec_start <= 1'b0;
      alarm_new <= 12'h000;
      // Tick caught here wins over start-of-sweep clear
      if (!init && !ph && idx == 7'd0) begin
        sweep_tick <= tick_pend | tick;
        tick_pend  <= 1'b0;
      end else if (tick) begin
        tick_pend  <= 1'b1;
      end
      if (init) begin
        idx <= last ? 7'd0 : idx + 7'd1;
        if (last) begin
          init <= 1'b0;
        end
      end else if (!ph) begin
        ph <= 1'b1;
      end else begin
        ph <= 1'b0;
        if (slot_rise && cfg_rd[`ARC_C_REC]) begin
          rec_start <= 1'b1;
        end
        if (last) begin
          idx        <= 7'd0;
          ch         <= 5'd0;
          alm        <= 3'd0;
          alarm_req  <= req_now;
          alarm_new  <= new_now;
          chan_alarm <= chan_now;
          acc_req    <= 12'h000;
          acc_new    <= 12'h000;
          acc_chan   <= 18'h0_0000;
        end else begin
          idx      <= idx + 7'd1;
          alm      <= (alm == `ARC_ALMS - 1) ? 3'd0 : alm + 3'd1;
          ch       <= (alm == `ARC_ALMS - 1) ? ch + 5'd1 : ch;
          acc_req  <= req_now;
          acc_new  <= new_now;
          acc_chan <= chan_now;
        end
      end
    end
  end

  reg [11:0] eff;
  always @* begin
    eff = (man_act & man_val) | (~man_act & energ);
  end

  genvar r;
  generate
    for (r = 0; r < `ARC_RELAYS; r = r + 1) begin : g_rly
      wire [1:0] typ = rly_type[2*r +: 2];
      wire       al  = alarm_req[r];
      wire       on  = al & ~ack_hold[r] & ~rst_hold[r];
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          energ[r]      <= 1'b0;
          ack_hold[r]   <= 1'b0;
          rst_hold[r]   <= 1'b0;
          flash[r]      <= 1'b0;
          man_act[r]    <= 1'b0;
          man_val[r]    <= 1'b0;
          alarm_prev[r] <= 1'b0;
        end else begin
          alarm_prev[r] <= al;
          if (cmd_ack && rly_ackc[r] && typ != `ARC_R_LATCH && al) begin
            ack_hold[r] <= 1'b1;
          end else if (!al) begin
            ack_hold[r] <= 1'b0;
          end
          if (cmd_rst && rly_oor[r] && al) begin
            rst_hold[r] <= 1'b1;
          end else if (!al) begin
            rst_hold[r] <= 1'b0;
          end
          if (typ == `ARC_R_LATCH) begin
            if (cmd_ack || (cmd_rst && (!al || rly_oor[r]))) begin
              energ[r] <= 1'b0;
            end else begin
              energ[r] <= energ[r] | on;
            end
          end else begin
            energ[r] <= on;
          end
          if (typ == `ARC_R_REFLASH && alarm_new[r] && energ[r]) begin
            flash[r] <= 1'b1;
          end else if (tick) begin
            flash[r] <= 1'b0;
          end
          if (man_set[r] || man_rst[r]) begin
            man_act[r] <= 1'b1;
            man_val[r] <= man_set[r];
          end else if (al != alarm_prev[r] || (cmd_rst && rly_oor[r])) begin
            man_act[r] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_drive   <= 12'h000;
      relay_summary <= 1'b0;
      alarm_audible <= 1'b0;
      muted         <= 1'b0;
    end else begin
      relay_drive   <= {12{ctrl[`ARC_CTRL_OUT]}} & rly_en & ((eff & ~flash) ^ rly_fs);
      relay_summary <= ctrl[`ARC_CTRL_OUT] & |(eff & rly_en);
      if (|alarm_new) begin
        muted <= 1'b0;
      end else if (cmd_ack) begin
        muted <= 1'b1;
      end
      alarm_audible <= (chan_alarm != 18'h0_0000) & ~muted;
    end
  end
endmodule // arc_top

// ---- tb/arc_contacts.sv ----
`timescale 1ns/1ps
// Relay contact bank: contacts follow the coil one cycle late
module arc_contacts (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // Coil drive
  input  wire [11:0] drive,
  // Contact state
  output reg  [11:0] closed
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      closed <= 12'h000;
    end else begin
      closed <= drive;
    end
  end
endmodule // arc_contacts

// ---- tb/arc_top_monitor.sv ----
`timescale 1ns/1ps
module arc_top_monitor (
  // APB
  input wire         pclk,
  input wire         presetn,
  input wire         psel,
  input wire         penable,
  input wire         pwrite,
  input wire [11:0]  paddr,
  input wire [31:0]  pwdata,
  input wire         pready,
  input wire [31:0]  prdata,
  input wire         pslverr,
  // Channels
  input wire [287:0] chan_value,
  input wire [17:0]  chan_abnormal,
  // Outputs
  input wire [11:0]  relay_drive,
  input wire         relay_summary,
  input wire         alarm_audible,
  input wire         rec_start
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rst_clear;
    $rose(presetn) |-> relay_drive == 12'h000 && !relay_summary && !alarm_audible && !rec_start;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  property p_init_wait;
    $rose(presetn) |-> !pready [*8];
  endproperty
  a_init_wait: assert property (p_init_wait) else $error("ready during init sweep");
  property p_pready_hold;
    pready |=> pready;
  endproperty
  a_pready_hold: assert property (p_pready_hold) else $error("ready dropped");
  property p_err_unmapped;
    psel && penable && pready && paddr == 12'h040 |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error on unmapped");
  property p_err_mapped;
    psel && penable && paddr < 12'h038 |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("error on mapped");
  property p_rec_pulse;
    rec_start |=> !rec_start;
  endproperty
  a_rec_pulse: assert property (p_rec_pulse) else $error("record start too long");
  property p_prdata_hold;
    !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
  property p_err_zero;
    psel && penable && !pwrite && pslverr |-> prdata == 32'h0000_0000;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  c_rec: cover property (rec_start);
  c_sum: cover property ($rose(relay_summary));
  c_err: cover property (pslverr);
endmodule // arc_top_monitor

bind arc_top arc_top_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .chan_value(chan_value), .chan_abnormal(chan_abnormal), .relay_drive(relay_drive),
  .relay_summary(relay_summary), .alarm_audible(alarm_audible), .rec_start(rec_start)
);

// ---- tb/alarm_relay_controller_tb.sv ----
`timescale 1ns/1ps
module alarm_relay_controller_tb;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = 0;
  logic [31:0]  pwdata = 0, prdata, r;
  logic         pready, pslverr, relay_summary, alarm_audible, rec_start, rec_seen = 0;
  logic [287:0] chan_value = 0;
  logic [11:0]  relay_drive, contact;
  logic [17:0]  chan_abn = 0;
  int           fail_count = 0, cmp_count = 0;
  int           on3 = 0, off1 = 0, n1 = 0;

  always #2 pclk = ~pclk;
  always @(posedge pclk) if (rec_start === 1'b1) rec_seen <= 1'b1;
  // Cycles relay 4 driven, cycles relay 2 open
  always @(posedge pclk) if (relay_drive[3] === 1'b1) on3 <= on3 + 1;
  always @(posedge pclk) if (relay_drive[1] === 1'b0) off1 <= off1 + 1;

  arc_top #(.TICK_CYCLES(400), .RELAYS_PRESENT(12'h0ff)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .chan_value(chan_value), .chan_abnormal(chan_abn), .relay_drive(relay_drive),
    .relay_summary(relay_summary), .alarm_audible(alarm_audible), .rec_start(rec_start));
  arc_contacts u_rly (.pclk(pclk), .presetn(presetn), .drive(relay_drive), .closed(contact));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Held until ready seen at a rising edge
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, exp);
  endtask
  task val(input logic [15:0] v);
    @(posedge pclk);
    chan_value[15:0] <= v;
    repeat (400) @(posedge pclk);
  endtask
  task drv(input logic [11:0] exp);
    chk({20'h0_0000, relay_drive}, {20'h0_0000, exp});
  endtask

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    wr(12'h000, 32'h0000_0003);
    wr(12'h010, 32'h0000_0fff);
    rdc(12'h010, 32'h0000_00ff);
    rdc(12'h040, 32'h0000_0000);
    // Chan 0 slot 0: high, sp 100, db 10, record, relay 1
    wr(12'h400, 32'h000a_0064);
    wr(12'h404, 32'h0390_0000);
    val(16'h0065);
    drv(12'h000);
    wr(12'h004, 32'h0000_0001);
    val(16'h0064);
    drv(12'h000);
    $display("test enables done");
    val(16'h0065);
    drv(12'h001);
    chk({31'h0, relay_summary}, 1);
    chk({31'h0, rec_seen}, 1);
    chk({20'h0_0000, contact}, 32'h0000_0001);
    rdc(12'h034, 32'h0000_0001);
    chk({31'h0, alarm_audible}, 1);
    wr(12'h024, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    chk({31'h0, alarm_audible}, 0);
    rdc(12'h00c, 32'h0000_0003);
    val(16'h005f);
    drv(12'h001);
    val(16'h0059);
    drv(12'h000);
    val(16'h005f);
    drv(12'h000);
    $display("test threshold done");
    wr(12'h014, 32'h0000_0001);
    val(16'h005f);
    drv(12'h001);
    val(16'h0065);
    drv(12'h000);
    wr(12'h014, 32'h0000_0000);
    val(16'h0065);
    drv(12'h001);
    wr(12'h000, 32'h0000_0001);
    val(16'h0065);
    drv(12'h000);
    chk({31'h0, relay_summary}, 0);
    wr(12'h000, 32'h0000_0003);
    wr(12'h018, 32'h0000_0001);
    wr(12'h024, 32'h0000_0002);
    val(16'h0065);
    drv(12'h000);
    wr(12'h018, 32'h0000_0000);
    val(16'h0032);
    $display("test output done");
    wr(12'h020, 32'h0000_0001);
    val(16'h0065);
    drv(12'h001);
    val(16'h0032);
    drv(12'h001);
    wr(12'h024, 32'h0000_0002);
    val(16'h0032);
    drv(12'h000);
    wr(12'h020, 32'h0000_0000);
    wr(12'h000, 32'h0000_0001);
    wr(12'h028, 32'h0000_0004);
    wr(12'h000, 32'h0000_0003);
    val(16'h0032);
    drv(12'h000);
    wr(12'h028, 32'h0000_0004);
    val(16'h0032);
    drv(12'h004);
    wr(12'h02c, 32'h0000_0004);
    val(16'h0032);
    drv(12'h000);
    $display("test relay modes done");
    // Contact channel 1 given an analog type
    wr(12'h008, 32'h0000_0002);
    wr(12'h428, 32'h0000_0001);
    wr(12'h42c, 32'h0090_0000);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk({31'h0, r[2]}, 1);
    wr(12'h024, 32'h0000_0004);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk({31'h0, r[2]}, 0);
    $display("test config error done");
    // Chan 0 slot 1: low, sp 20, db 5, delay 2 s, relay 2
    wr(12'h408, 32'h0005_0014);
    wr(12'h40c, 32'h04a0_0002);
    // Chan 0 slot 3: rate, sp 10, window 1 s, relay 4
    wr(12'h418, 32'h0000_000a);
    wr(12'h41c, 32'h08b0_0400);
    val(16'h0013);
    drv(12'h000);
    repeat (1600) @(posedge pclk);
    drv(12'h002);
    val(16'h0018);
    drv(12'h002);
    chk(on3, 0);
    // Relay 2 reflash; chan 2 slot 0 abnormal onto relay 2
    wr(12'h020, 32'h0000_0008);
    wr(12'h004, 32'h0000_0005);
    wr(12'h450, 32'h0000_0000);
    wr(12'h454, 32'h04c0_0000);
    n1 = off1;
    chan_abn <= 18'h0_0004;
    val(16'h0018);
    chk({31'h0, off1 != n1}, 1);
    rdc(12'h034, 32'h0000_0005);
    chan_abn <= 18'h0_0000;
    val(16'h0019);
    drv(12'h000);
    val(16'h0032);
    repeat (500) @(posedge pclk);
    chk({31'h0, on3 != 0}, 1);
    $display("test low rate reflash done");
    end_of_test;
  end

  initial begin
    #300000;
    fail_count++;
    end_of_test;
  end
endmodule // alarm_relay_controller_tb
